// *** uhbpm_pkg.sv ***
/*
  Shared constants and types for the UART host bus pin mode logic.
  Assumes a single 250 MHz clock domain and pins already synchronous to it.
*/
`default_nettype none

package uhbpm_pkg;

  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Bus personality sampled at reset
  typedef enum logic {
    UHBPM_MODE_MPU,
    UHBPM_MODE_PC
  } uhbpm_mode_t;

  // Prescaler: divide-by-4 runs a wrapping two-bit counter; divide-by-1 holds it at zero
  localparam logic [1:0] PRESC_LAST    = 2'h3;
  localparam logic [1:0] PRESC_ZERO    = 2'h0;

  // Modem control bits used by the pin logic
  localparam int unsigned MCR_IRQ_EN_BIT = 3;
  localparam int unsigned MCR_PRESC_BIT  = 7;

  // High data bus lanes (pins 10, 11, 12)
  localparam int unsigned HI_PARITY  = 0;
  localparam int unsigned HI_FRAMING = 1;
  localparam int unsigned HI_BREAK   = 2;

  // Interrupt line indices (a, b, c)
  localparam logic [1:0] IRQ_LINE_A   = 2'h0;
  localparam logic [1:0] IRQ_LINE_B   = 2'h1;
  localparam logic [1:0] IRQ_LINE_C   = 2'h2;
  localparam logic [1:0] IRQ_LINE_OFF = 2'h3;

  // Address bits 9..3 of the standard serial and printer port bases
  localparam logic [6:0] COM1_BASE_HI = 7'h7f;
  localparam logic [6:0] COM2_BASE_HI = 7'h5f;
  localparam logic [6:0] COM3_BASE_HI = 7'h7d;
  localparam logic [6:0] COM4_BASE_HI = 7'h5d;
  localparam logic [6:0] PRINTER1_DECODE_N_BASE_HI = 7'h6f;
  localparam logic [6:0] PRINTER2_DECODE_N_BASE_HI = 7'h4f;

  // Port-select code to port base, and port-select code to interrupt line
  localparam logic [55:0] PORT_BASE_TABLE = {
    COM4_BASE_HI, COM3_BASE_HI, COM2_BASE_HI, COM1_BASE_HI,
    COM4_BASE_HI, COM3_BASE_HI, COM2_BASE_HI, COM1_BASE_HI};
  localparam logic [15:0] PORT_IRQ_TABLE = {
    IRQ_LINE_C, IRQ_LINE_B, IRQ_LINE_C, IRQ_LINE_A,
    IRQ_LINE_B, IRQ_LINE_A, IRQ_LINE_B, IRQ_LINE_A};

endpackage

`default_nettype wire

// *** uhbpm_pins.sv ***
/*
  Host-side pin multiplexing of a UART: bus mode and width selection,
  address strobe latching, ready and interrupt pins, prescaler, receive
  clock routing, drive disable and PC port address decoding.
  Assumes the UART core supplies status levels and a 16x baud tick, and
  that every pin input is already synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

// Function
// - Transmit-ready pin low while holding register or FIFO has a free location.
// - Address strobe falling edge latches chip selects and low address lines.
// - Sixteen-bit bus shows parity, framing, break on data bits 10, 11, 12.
// - Eight-bit bus: bits 10, 11 idle, bit 12 pin is drive disable.
// - PC mode forbids 16-bit bus; bit 12 pin becomes printer 2 decode.
// - Prescaler divides by 1 with select pin high, by 4 when low.
// - Modem control bit 7 can override the prescaler pin choice.
// - Baud output is active-low 16x clock; receiver uses the receive clock.
// - PC mode routes baud clock internally; baud pin becomes printer 1 decode.
// - Drive disable low while the host reads from the device.
// - PC mode decodes serial address chosen by port selects on enable fall.
// - PC mode uses address lines 3 to 9 as address bits for decoding.
// - Printer decode outputs go low on matching printer port addresses.
// - PC interrupt lines active high, three-state, driven with bit 3 and enables.
// - Processor mode interrupt pins are interrupt, receive-ready, transmit-ready.
// - Processor mode address pins 5-8 are selects and write; pin 3 reads.
// - Processor mode ignores A4, A9, select 1; selects 2, 3 are clock, output.
// - Selected only with both high selects high and the low select low.
// - Receive-ready pin low when holding register full or FIFO non-empty.
// - Host write stores to register indexed by address 2..0 at strobe end.
module uhbpm_pins #(
  parameter logic [55:0] PORT_BASE = uhbpm_pkg::PORT_BASE_TABLE,
  parameter logic [15:0] PORT_IRQ  = uhbpm_pkg::PORT_IRQ_TABLE,
  parameter logic [6:0]  PRINTER1_DECODE_N_BASE = uhbpm_pkg::PRINTER1_DECODE_N_BASE_HI,
  parameter logic [6:0]  PRINTER2_DECODE_N_BASE = uhbpm_pkg::PRINTER2_DECODE_N_BASE_HI
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       mode_select_n,
  input  wire logic       bus_width_select,
  input  wire logic       prescale_pin_select,
  input  wire logic [2:0] addr_low,
  input  wire logic       pin_a3,
  input  wire logic       pin_a4,
  input  wire logic       pin_a5,
  input  wire logic       pin_a6,
  input  wire logic       pin_a7,
  input  wire logic       pin_a8,
  input  wire logic       pin_a9,
  input  wire logic       addr_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic       port_select_1,
  input  wire logic       port_select_2,
  input  wire logic       port_select_3_i,
  output logic            port_select_3_o,
  output logic            port_select_3_oe,
  output logic            irq_line_a,
  output logic            irq_line_a_oe,
  output logic            irq_line_b,
  output logic            irq_line_b_oe,
  output logic            irq_line_c,
  output logic            irq_line_c_oe,
  output logic [2:0]      hi_data_o,
  output logic [2:0]      hi_data_oe,
  output logic            baud_gen_out_n,
  input  wire logic       tx_space_avail,
  input  wire logic       rx_char_avail,
  input  wire logic       core_int,
  input  wire logic [2:0] rx_err_flags,
  input  wire logic [7:0] modem_control_reg,
  input  wire logic [3:0] interrupt_enable_reg,
  input  wire logic       baud_tick_16x,
  output logic            presc_en,
  output logic            rx_sample_en,
  output logic            reg_wr_pulse,
  output logic            reg_rd_active,
  output logic [2:0]      reg_index,
  output logic            pc_mode,
  output logic            bus_is_16
);

  // Strap capture
  logic                  strap_done_r, strap_done_nxt;
  uhbpm_pkg::uhbpm_mode_t mode_r, mode_nxt;
  logic                  width16_r, width16_nxt;
  logic                  div4_pin_r, div4_pin_nxt;
  always_comb begin
    strap_done_nxt = 1'b1;
    mode_nxt       = mode_r;
    width16_nxt    = width16_r;
    div4_pin_nxt   = div4_pin_r;
    // First edge after reset release catches the straps, then they freeze
    if (!strap_done_r) begin
      mode_nxt     = mode_select_n ? uhbpm_pkg::UHBPM_MODE_MPU
                                   : uhbpm_pkg::UHBPM_MODE_PC;
      width16_nxt  = !bus_width_select;
      div4_pin_nxt = !prescale_pin_select;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_done_r <= 1'b0;
      mode_r       <= uhbpm_pkg::UHBPM_MODE_MPU;
      width16_r    <= 1'b0;
      div4_pin_r   <= 1'b0;
    end else begin
      strap_done_r <= strap_done_nxt;
      mode_r       <= mode_nxt;
      width16_r    <= width16_nxt;
      div4_pin_r   <= div4_pin_nxt;
    end
  end

  logic is_pc;
  logic wide;
  assign is_pc = (mode_r == uhbpm_pkg::UHBPM_MODE_PC);
  assign wide  = width16_r && !is_pc;
  // Address strobe latch and host access tracking
  logic [2:0] lat_cs_r, lat_cs_nxt;
  logic [2:0] lat_addr_r, lat_addr_nxt;
  logic       as_prev_r, as_prev_nxt;
  logic       as_seen_hi_r, as_seen_hi_nxt;
  logic       wr_prev_r, wr_prev_nxt;
  logic [2:0] wr_index_r, wr_index_nxt;
  logic [6:0] pc_addr_r, pc_addr_nxt;
  logic       pc_valid_r, pc_valid_nxt;
  logic [2:0] pc_sel_r, pc_sel_nxt;
  logic [2:0] live_cs;
  logic [2:0] use_cs;
  logic [2:0] use_addr;
  logic [6:0] live_pc_addr;
  logic       mpu_sel;
  logic       pc_sel_hit;
  logic       host_sel;
  logic       rd_now;
  logic       wr_now;
  assign live_cs      = {pin_a7, pin_a6, pin_a5};
  assign live_pc_addr = {pin_a9, pin_a8, pin_a7, pin_a6, pin_a5, pin_a4, pin_a3};
  always_comb begin
    lat_cs_nxt     = lat_cs_r;
    lat_addr_nxt   = lat_addr_r;
    as_prev_nxt    = addr_strobe_n;
    as_seen_hi_nxt = as_seen_hi_r || addr_strobe_n;
    pc_addr_nxt    = pc_addr_r;
    pc_sel_nxt     = pc_sel_r;
    pc_valid_nxt   = pc_valid_r;
    // Capture on the falling edge; a strobe that stays high tracks the pins
    if (addr_strobe_n) begin
      lat_cs_nxt   = live_cs;
      lat_addr_nxt = addr_low;
      pc_valid_nxt = 1'b0;
    end else if (as_prev_r) begin
      lat_cs_nxt   = live_cs;
      lat_addr_nxt = addr_low;
      pc_addr_nxt  = live_pc_addr;
      pc_sel_nxt   = {port_select_3_i, port_select_2, port_select_1};
      pc_valid_nxt = 1'b1;
    end
  end

  // A strobe tied low since reset never falls, so the live pins are used
  assign use_cs   = as_seen_hi_r ? (addr_strobe_n ? live_cs : lat_cs_r) : live_cs;
  assign use_addr = as_seen_hi_r ? (addr_strobe_n ? addr_low : lat_addr_r) : addr_low;
  assign mpu_sel    = use_cs[0] && use_cs[1] && !use_cs[2];
  assign pc_sel_hit = pc_valid_r && (pc_addr_r == PORT_BASE[pc_sel_r*7 +: 7]);
  assign host_sel   = is_pc ? pc_sel_hit : mpu_sel;
  assign rd_now     = host_sel && (!read_strobe_n || (!is_pc && pin_a3));
  assign wr_now     = host_sel && (!write_strobe_n || (!is_pc && pin_a8));
  always_comb begin
    wr_prev_nxt  = wr_now;
    wr_index_nxt = wr_now ? use_addr : wr_index_r;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lat_cs_r     <= 3'h0;
      lat_addr_r   <= 3'h0;
      as_prev_r    <= 1'b1;
      as_seen_hi_r <= 1'b0;
      pc_addr_r    <= 7'h00;
      pc_sel_r     <= 3'h0;
      pc_valid_r   <= 1'b0;
      wr_prev_r    <= 1'b0;
      wr_index_r   <= 3'h0;
    end else begin
      lat_cs_r     <= lat_cs_nxt;
      lat_addr_r   <= lat_addr_nxt;
      as_prev_r    <= as_prev_nxt;
      as_seen_hi_r <= as_seen_hi_nxt;
      pc_addr_r    <= pc_addr_nxt;
      pc_sel_r     <= pc_sel_nxt;
      pc_valid_r   <= pc_valid_nxt;
      wr_prev_r    <= wr_prev_nxt;
      wr_index_r   <= wr_index_nxt;
    end
  end

  // Prescaler and receive clock
  logic [1:0] presc_cnt_r, presc_cnt_nxt;
  logic       presc_en_r, presc_en_nxt;
  logic       rclk_prev_r, rclk_prev_nxt;
  logic       rx_en_r, rx_en_nxt;
  logic       baud_n_r, baud_n_nxt;
  logic       div4;
  // Bit 7 only ever forces divide-by-4, so unstrapped packages still get it
  assign div4 = div4_pin_r || modem_control_reg[uhbpm_pkg::MCR_PRESC_BIT];
  always_comb begin
    presc_cnt_nxt = presc_cnt_r + 2'h1;
    presc_en_nxt  = 1'b1;
    if (div4) begin
      presc_en_nxt = (presc_cnt_r == uhbpm_pkg::PRESC_LAST);
    end else begin
      presc_cnt_nxt = uhbpm_pkg::PRESC_ZERO;
    end
    rclk_prev_nxt = port_select_2;
    rx_en_nxt     = is_pc ? baud_tick_16x
                          : (port_select_2 && !rclk_prev_r);
    baud_n_nxt    = is_pc ? !(pc_addr_r == PRINTER1_DECODE_N_BASE && pc_valid_r)
                          : !baud_tick_16x;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_cnt_r <= uhbpm_pkg::PRESC_ZERO;
      presc_en_r  <= 1'b0;
      rclk_prev_r <= 1'b0;
      rx_en_r     <= 1'b0;
      baud_n_r    <= 1'b1;
    end else begin
      presc_cnt_r <= presc_cnt_nxt;
      presc_en_r  <= presc_en_nxt;
      rclk_prev_r <= rclk_prev_nxt;
      rx_en_r     <= rx_en_nxt;
      baud_n_r    <= baud_n_nxt;
    end
  end

  // Pin drivers
  logic [2:0] irq_r, irq_nxt;
  logic [2:0] irq_oe_r, irq_oe_nxt;
  logic [2:0] hi_r, hi_nxt;
  logic [2:0] hi_oe_r, hi_oe_nxt;
  logic       op2_r, op2_nxt;
  logic       op2_oe_r, op2_oe_nxt;
  logic       wr_pulse_r, wr_pulse_nxt;
  logic       rd_act_r, rd_act_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [1:0] pc_line;
  logic       pc_irq_on;
  assign pc_line   = PORT_IRQ[pc_sel_r*2 +: 2];
  assign pc_irq_on = modem_control_reg[uhbpm_pkg::MCR_IRQ_EN_BIT]
                     && (|interrupt_enable_reg);
  always_comb begin
    irq_nxt    = 3'h0;
    irq_oe_nxt = 3'h0;
    hi_nxt     = 3'h0;
    hi_oe_nxt  = 3'h0;
    if (is_pc) begin
      // Only the line chosen by the port selects is ever enabled
      for (int i = 0; i < 3; i++) begin
        if (pc_irq_on && (pc_line == 2'(i))) begin
          irq_nxt[i]    = core_int;
          irq_oe_nxt[i] = 1'b1;
        end
      end
      hi_nxt[uhbpm_pkg::HI_BREAK]    = !(pc_valid_r && pc_addr_r == PRINTER2_DECODE_N_BASE);
      hi_oe_nxt[uhbpm_pkg::HI_BREAK] = 1'b1;
    end else begin
      irq_nxt    = {!tx_space_avail, !rx_char_avail, core_int};
      irq_oe_nxt = 3'h7;
      if (wide) begin
        hi_nxt    = rx_err_flags;
        hi_oe_nxt = rd_now ? 3'h7 : 3'h0;
      end else begin
        hi_nxt[uhbpm_pkg::HI_BREAK]    = !rd_now;
        hi_oe_nxt[uhbpm_pkg::HI_BREAK] = 1'b1;
      end
    end
    op2_nxt      = !modem_control_reg[uhbpm_pkg::MCR_IRQ_EN_BIT];
    op2_oe_nxt   = !is_pc;
    wr_pulse_nxt = wr_prev_r && !wr_now;
    rd_act_nxt   = rd_now;
    idx_nxt      = (wr_prev_r && !wr_now) ? wr_index_r : use_addr;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_r      <= 3'h0;
      irq_oe_r   <= 3'h0;
      hi_r       <= 3'h0;
      hi_oe_r    <= 3'h0;
      op2_r      <= 1'b1;
      op2_oe_r   <= 1'b0;
      wr_pulse_r <= 1'b0;
      rd_act_r   <= 1'b0;
      idx_r      <= 3'h0;
    end else begin
      irq_r      <= irq_nxt;
      irq_oe_r   <= irq_oe_nxt;
      hi_r       <= hi_nxt;
      hi_oe_r    <= hi_oe_nxt;
      op2_r      <= op2_nxt;
      op2_oe_r   <= op2_oe_nxt;
      wr_pulse_r <= wr_pulse_nxt;
      rd_act_r   <= rd_act_nxt;
      idx_r      <= idx_nxt;
    end
  end

  assign irq_line_a       = irq_r[0];
  assign irq_line_a_oe    = irq_oe_r[0];
  assign irq_line_b       = irq_r[1];
  assign irq_line_b_oe    = irq_oe_r[1];
  assign irq_line_c       = irq_r[2];
  assign irq_line_c_oe    = irq_oe_r[2];
  assign hi_data_o        = hi_r;
  assign hi_data_oe       = hi_oe_r;
  assign port_select_3_o  = op2_r;
  assign port_select_3_oe = op2_oe_r;
  assign baud_gen_out_n   = baud_n_r;
  assign presc_en         = presc_en_r;
  assign rx_sample_en     = rx_en_r;
  assign reg_wr_pulse     = wr_pulse_r;
  assign reg_rd_active    = rd_act_r;
  assign reg_index        = idx_r;
  assign pc_mode          = is_pc;
  assign bus_is_16        = wide;

endmodule

`default_nettype wire

// *** uhbpm_pins_sva.sv ***
/*
  Concurrent checks on the ports of the host bus pin logic.
  Assumes the strap pins only change while reset is held.
*/
`timescale 1ns/1ps
`default_nettype none
module uhbpm_pins_chk (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       prescale_pin_select,
  input wire logic       tx_space_avail,
  input wire logic       rx_char_avail,
  input wire logic       core_int,
  input wire logic [2:0] rx_err_flags,
  input wire logic [7:0] modem_control_reg,
  input wire logic [3:0] interrupt_enable_reg,
  input wire logic       irq_line_a,
  input wire logic       irq_line_a_oe,
  input wire logic       irq_line_b,
  input wire logic       irq_line_b_oe,
  input wire logic       irq_line_c,
  input wire logic       irq_line_c_oe,
  input wire logic       port_select_3_o,
  input wire logic       port_select_3_oe,
  input wire logic [2:0] hi_data_o,
  input wire logic [2:0] hi_data_oe,
  input wire logic       presc_en,
  input wire logic       reg_wr_pulse,
  input wire logic       reg_rd_active,
  input wire logic       pc_mode,
  input wire logic       bus_is_16
);
  logic [1:0] up_r;
  logic [1:0] up_nxt;
  // Pin outputs follow the strapped mode only from the second edge after release
  wire        rdy    = (up_r == 2'h3);
  wire        irq_en = modem_control_reg[uhbpm_pkg::MCR_IRQ_EN_BIT];

  always_comb up_nxt = rdy ? up_r : up_r + 2'h1;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) up_r <= 2'h0;
    else up_r <= up_nxt;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_tx_ready_pin: assert property (
    rdy && !pc_mode |-> irq_line_c == !$past(tx_space_avail) && irq_line_c_oe)
    else $error("tx ready pin wrong");
  chk_rx_ready_pin: assert property (
    rdy && !pc_mode |-> irq_line_b == !$past(rx_char_avail) && irq_line_b_oe)
    else $error("rx ready pin wrong");
  chk_int_pin: assert property (
    rdy && !pc_mode |-> irq_line_a == $past(core_int) && irq_line_a_oe)
    else $error("interrupt pin wrong");
  chk_pc_irq_off: assert property (
    rdy && pc_mode && (!$past(irq_en) || $past(interrupt_enable_reg) == 4'h0)
      |-> !(irq_line_a_oe || irq_line_b_oe || irq_line_c_oe))
    else $error("irq line driven while disabled");
  chk_pc_narrow: assert property (pc_mode |-> !bus_is_16)
    else $error("wide bus in pc mode");
  chk_wr_single: assert property (reg_wr_pulse |=> !reg_wr_pulse)
    else $error("write pulse too long");
  chk_div_four: assert property (
    presc_en && !prescale_pin_select |=> !presc_en [*3])
    else $error("divide by four spacing wrong");
  chk_drive_disable: assert property (
    rdy && !pc_mode && !bus_is_16 && reg_rd_active
      |-> !hi_data_o[2] && hi_data_oe[2] && hi_data_oe[1:0] == 2'h0)
    else $error("drive disable not low in read");
  chk_wide_errs: assert property (
    rdy && bus_is_16 && reg_rd_active |-> hi_data_oe == 3'h7 && hi_data_o == $past(rx_err_flags))
    else $error("error flags not on high lanes");
  chk_gp_output: assert property (
    rdy && !pc_mode |-> port_select_3_o == !$past(irq_en) && port_select_3_oe)
    else $error("general output wrong");
endmodule

bind uhbpm_pins uhbpm_pins_chk chk_u (.*);
`default_nettype wire

// *** uhbpm_host.sv ***
/*
  Host bus model: drives the processor or PC bus pins of the pin logic.
  Assumes the testbench sets pc for the bus personality and calls the tasks.
*/
`timescale 1ns/1ps
`default_nettype none
module uhbpm_host (
  input  wire logic       clk,
  input  wire logic       baud_gen_out_n,
  output logic      [2:0] addr_low,
  output logic            pin_a3,
  output logic            pin_a4,
  output logic            pin_a5,
  output logic            pin_a6,
  output logic            pin_a7,
  output logic            pin_a8,
  output logic            pin_a9,
  output logic            addr_strobe_n,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic            port_select_1,
  output logic            port_select_2,
  output logic            port_select_3_i
);
  logic pc;
  logic s2;
  // Processor mode: receive clock wired back from the baud output
  assign port_select_2 = pc ? s2 : baud_gen_out_n;

  initial begin
    pc = 1'b0;
    s2 = 1'b0;
    addr_low = 3'h0;
    {pin_a9, pin_a8, pin_a7, pin_a6, pin_a5, pin_a4, pin_a3} = 7'h10;
    addr_strobe_n = 1'b0; // Tied low while addresses stay stable
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    port_select_1 = 1'b0;
    port_select_3_i = 1'b0;
  end

  task automatic strobe(input logic wr, input int len);
    if (wr) write_strobe_n = 1'b0;
    else read_strobe_n = 1'b0;
    repeat (len) @(negedge clk);
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask

  task automatic mpu_cycle(input logic wr, input logic [2:0] cs, input logic [2:0] a,
                           input logic latch, input int len);
    @(negedge clk);
    addr_strobe_n = latch;
    addr_low = a;
    {pin_a7, pin_a6, pin_a5} = cs;
    @(negedge clk);
    addr_strobe_n = 1'b0;
    @(negedge clk);
    if (latch) begin
      // Lines go stale after the strobe edge; only the latched copy is good
      addr_low = ~a;
      {pin_a7, pin_a6, pin_a5} = 3'h4;
    end
    strobe(wr, len);
    addr_low = ~a;
    {pin_a7, pin_a6, pin_a5} = 3'h4;
  endtask

  // Processor mode active-high strobes on the shared address pins
  task automatic act_high(input logic wr, input int len);
    @(negedge clk);
    {pin_a7, pin_a6, pin_a5} = 3'h3;
    if (wr) pin_a8 = 1'b1;
    else pin_a3 = 1'b1;
    repeat (len) @(negedge clk);
    {pin_a8, pin_a3} = 2'h0;
    repeat (3) @(negedge clk);
    {pin_a7, pin_a6, pin_a5} = 3'h4;
  endtask

  task automatic pc_decode(input logic [6:0] hi, input logic [2:0] code);
    @(negedge clk);
    addr_strobe_n = 1'b1;
    {pin_a9, pin_a8, pin_a7, pin_a6, pin_a5, pin_a4, pin_a3} = hi;
    {port_select_3_i, s2, port_select_1} = code;
    @(negedge clk);
    addr_strobe_n = 1'b0;
    repeat (3) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// *** uhbpm_pins_tb.sv ***
/*
  Self-checking testbench for the host bus pin logic.
  Assumes the host model drives the bus pins; core levels come from here.
*/
`timescale 1ns/1ps
`default_nettype none
module uhbpm_pins_tb;
  logic            clk, arst_n, mode_select_n, bus_width_select, prescale_pin_select;
  logic            tx_space_avail, rx_char_avail, core_int, baud_tick_16x;
  logic      [2:0] rx_err_flags;
  logic      [7:0] modem_control_reg;
  logic      [3:0] interrupt_enable_reg;
  wire logic [2:0] addr_low, hi_data_o, hi_data_oe, reg_index;
  wire logic       pin_a3, pin_a4, pin_a5, pin_a6, pin_a7, pin_a8, pin_a9;
  wire logic       addr_strobe_n, read_strobe_n, write_strobe_n, port_select_1;
  wire logic       port_select_2, port_select_3_i, port_select_3_o, port_select_3_oe;
  wire logic       irq_line_a, irq_line_a_oe, irq_line_b, irq_line_b_oe, irq_line_c;
  wire logic       irq_line_c_oe, baud_gen_out_n, presc_en, rx_sample_en;
  wire logic       reg_wr_pulse, reg_rd_active, pc_mode, bus_is_16;
  int              fails, samples_checked, n_presc, n_rxs, n_baud, n_wr, n_rd, n_drive_disable_n;
  logic      [2:0] wr_idx;
  logic      [5:0] hi_cap;

  uhbpm_pins dut_u (.*);
  uhbpm_host host_u (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (presc_en === 1'b1) n_presc++;
    if (rx_sample_en === 1'b1) n_rxs++;
    if (baud_gen_out_n === 1'b0) n_baud++;
    if (reg_rd_active === 1'b1) n_rd++;
    if (reg_rd_active === 1'b1) hi_cap = {hi_data_oe, hi_data_o};
    if (hi_data_o[2] === 1'b0 && hi_data_oe[2] === 1'b1) n_drive_disable_n++;
    if (reg_wr_pulse === 1'b1) n_wr++;
    if (reg_wr_pulse === 1'b1) wr_idx = reg_index;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic clr;
    {n_presc, n_rxs, n_baud, n_wr, n_rd, n_drive_disable_n} = '0;
  endtask

  task automatic do_reset(input logic ms, input logic bw, input logic ps);
    @(negedge clk);
    arst_n = 1'b0;
    {mode_select_n, bus_width_select, prescale_pin_select} = {ms, bw, ps};
    modem_control_reg = 8'h00;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic ticks(input int n);
    clr();
    repeat (n) begin
      baud_tick_16x = 1'b1;
      @(negedge clk);
      baud_tick_16x = 1'b0;
      repeat (5) @(negedge clk);
    end
  endtask

  task automatic test_mpu8;
    logic [2:0] bad [3] = '{3'h7, 3'h1, 3'h2};
    do_reset(1'b1, 1'b1, 1'b1);
    chk({pc_mode, bus_is_16}, 2'h0, "straps");
    {tx_space_avail, rx_char_avail, core_int} = 3'b101;
    repeat (2) @(negedge clk);
    chk({irq_line_a, irq_line_b, irq_line_c}, 3'b110, "ready pins");
    {tx_space_avail, rx_char_avail, core_int} = 3'b010;
    repeat (2) @(negedge clk);
    chk({irq_line_a, irq_line_b, irq_line_c}, 3'b001, "ready pins");
    clr();
    repeat (8) @(negedge clk);
    chk(n_presc, 8, "divide by one");
    modem_control_reg = 8'h80;
    repeat (2) @(negedge clk);
    clr();
    repeat (8) @(negedge clk);
    chk(n_presc, 2, "bit 7 override");
    ticks(3);
    chk(n_baud, 3, "baud pulses");
    chk(n_rxs, 3, "receive samples");
    clr();
    host_u.mpu_cycle(1'b1, 3'h3, 3'h5, 1'b0, 2);
    chk(n_wr, 1, "write");
    chk(wr_idx, 3'h5, "write index");
    clr();
    for (int i = 0; i < 3; i++) host_u.mpu_cycle(1'b1, bad[i], 3'h2, 1'b0, 2);
    chk(n_wr, 0, "unselected write");
    clr();
    host_u.mpu_cycle(1'b0, 3'h3, 3'h1, 1'b0, 4);
    chk(n_rd, 4, "read length");
    chk(n_drive_disable_n, 4, "drive disable");
    clr();
    host_u.mpu_cycle(1'b1, 3'h3, 3'h6, 1'b1, 2);
    chk({n_wr[3:0], 1'b0, wr_idx}, 8'h16, "latched write");
    modem_control_reg = 8'h08;
    repeat (2) @(negedge clk);
    chk({port_select_3_o, port_select_3_oe}, 2'h1, "general output");
    $display("processor 8-bit test done");
  endtask

  task automatic test_mpu16;
    do_reset(1'b1, 1'b0, 1'b0);
    chk(bus_is_16, 1'b1, "wide bus");
    rx_err_flags = 3'h5;
    clr();
    host_u.mpu_cycle(1'b0, 3'h3, 3'h2, 1'b0, 3);
    chk(n_rd, 3, "wide read");
    chk(hi_cap, 6'h3d, "error lanes");
    clr();
    host_u.act_high(1'b0, 2);
    host_u.act_high(1'b1, 2);
    chk({n_rd[3:0], n_wr[3:0]}, 8'h21, "active high strobes");
    clr();
    repeat (8) @(negedge clk);
    chk(n_presc, 2, "divide by four");
    $display("processor 16-bit test done");
  endtask

  task automatic test_pc;
    logic [2:0] exp;
    host_u.pc = 1'b1;
    do_reset(1'b0, 1'b0, 1'b1);
    chk({pc_mode, bus_is_16}, 2'h2, "pc straps");
    ticks(3);
    chk({n_rxs[3:0], n_baud[3:0]}, 8'h30, "internal receive clock");
    host_u.pc_decode(uhbpm_pkg::PRINTER1_DECODE_N_BASE_HI, 3'h0);
    chk({baud_gen_out_n, hi_data_o[2]}, 2'h1, "printer 1");
    host_u.pc_decode(uhbpm_pkg::PRINTER2_DECODE_N_BASE_HI, 3'h0);
    chk({baud_gen_out_n, hi_data_o[2]}, 2'h2, "printer 2");
    {modem_control_reg, interrupt_enable_reg, core_int} = {8'h08, 4'h1, 1'b1};
    for (int i = 0; i < 8; i++) begin
      exp = 3'h1 << uhbpm_pkg::PORT_IRQ_TABLE[2*i +: 2];
      host_u.pc_decode(uhbpm_pkg::PORT_BASE_TABLE[7*i +: 7], i[2:0]);
      chk({irq_line_c_oe, irq_line_b_oe, irq_line_a_oe}, exp, "irq enable");
      chk({irq_line_c, irq_line_b, irq_line_a} & exp, exp, "irq level");
      n_wr = 0;
      host_u.strobe(1'b1, 2);
      chk(n_wr, 1, "serial write");
    end
    interrupt_enable_reg = 4'h0;
    repeat (2) @(negedge clk);
    chk({irq_line_c_oe, irq_line_b_oe, irq_line_a_oe}, 3'h0, "no sources");
    {modem_control_reg, interrupt_enable_reg} = {8'h00, 4'h1};
    repeat (2) @(negedge clk);
    chk({irq_line_c_oe, irq_line_b_oe, irq_line_a_oe}, 3'h0, "bit 3 clear");
    host_u.pc_decode(7'h00, 3'h0);
    n_wr = 0;
    host_u.strobe(1'b1, 2);
    chk(n_wr, 0, "unmatched write");
    $display("pc mode test done");
  endtask

  task automatic give_verdict;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    {arst_n, mode_select_n, bus_width_select, prescale_pin_select} = 4'h7;
    {tx_space_avail, rx_char_avail, core_int, baud_tick_16x} = 4'h0;
    {rx_err_flags, modem_control_reg, interrupt_enable_reg} = '0;
    {fails, samples_checked, wr_idx, hi_cap} = '0;
    clr();
    test_mpu8();
    test_mpu16();
    test_pc();
    give_verdict();
  end

  // The tests need about 270 cycles; about eighteen times that means a hang
  initial begin
    #20000;
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
